// file: rtl/ulpi_defines.svh
/*
 * Constants shared by both ends of the ULPI link model: command codes,
 * register addresses and fields, divider counts and host register map.
 * Assumes inclusion by bare name from files compiled under rtl/.
 */
`ifndef ULPI_DEFINES_SVH
`define ULPI_DEFINES_SVH

// Command type in bits 7:6 of the link command byte, extended-address code in bits 5:0, idle bus value
`define CMD_IDLE        2'h0
`define CMD_TX          2'h1
`define CMD_REG_WR      2'h2
`define CMD_REG_RD      2'h3
`define CMD_EXT_ADDR    6'h2F
`define BUS_IDLE        8'h00

// Register array addresses, fields and reset values
`define OTG_CTRL_ADDR   8'h0A
`define DRV_VBUS_POS    5
`define DRV_VBUS_EXT_POS 6
`define OTG_CTRL_RST    8'h00
`define IOPM_ADDR       8'h39
`define CHG_DP_POS      0
`define CHG_DM_POS      1
`define UART_LVL_LSB    2
`define IOPM_RST        8'h00
`define MODE_ADDR       8'h3A
`define MODE_LPM_POS    0
`define MODE_UART_POS   1
`define MODE_RST        8'h00

// Interface clock output: half period from hclk rate, rounded down
`define HCLK_PERIOD_PS  8000
`define PHY_CLK_HALF_PS 8333
`define PHY_CLK_HALF_CYC (`PHY_CLK_HALF_PS / `HCLK_PERIOD_PS)

// Host register map, byte offsets
`define LNK_CTRL_OFS    8'h00
`define LNK_STAT_OFS    8'h04
`define CTRL_CMD_LSB    0
`define CTRL_WDAT_LSB   8
`define CTRL_XADDR_LSB  16
`define CTRL_START_POS  24
`define CTRL_WAKE_POS   25
`define CTRL_RST        32'h00000000

`endif

// file: rtl/ulpi_if.sv
/*
 * ULPI wires between the device end and the link end.
 * Assumes both ends run on the same hclk; an undriven bus reads as idle.
 */
`timescale 1ns/10ps
interface ulpi_if;
	logic       dir;
	logic       nxt;
	logic       stp;
	logic       phy_clock_out;
	logic [7:0] phy_data_o;
	logic       phy_oe_n;
	logic [7:0] link_data_o;
	logic       link_oe_n;
	logic [7:0] data;

	// Resolved bus level; nobody driving gives the idle value
	assign data = !phy_oe_n ? phy_data_o :
		(!link_oe_n ? link_data_o : 8'h00);

	modport phy (output dir, nxt, phy_clock_out, phy_data_o, phy_oe_n,
		input stp, data);
	modport link (output stp, link_data_o, link_oe_n,
		input dir, nxt, phy_clock_out, data);
endinterface : ulpi_if

// file: rtl/ulpi_link_end.sv
/*
 * Link end of the ULPI interface with an AHB-Lite register slave that
 * issues register writes, reads, one-byte transmits and wake-ups.
 * Assumes a single AHB-Lite master and the device on the same hclk.
 */
`timescale 1ns/10ps
`include "ulpi_defines.svh"
module ulpi_link_end (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// Device side
	ulpi_if.link             bus,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp
);
	ulpi_pkg::link_state_t st_q;
	logic [31:0] ctrl_q;
	logic        a_act_q, a_wr_q, start_q, wake_req_q;
	logic [7:0]  a_ofs_q;
	logic        go_q, wake_q, done_q, xsent_q, stp_q, oe_n_q;
	logic [7:0]  dout_q, rdat_q, rxcmd_q;
	logic        dir_d1_q, dir_d2_q;
	logic        free, dvalid, ext;
	logic [7:0]  cmd;

	function automatic logic [31:0] stat_word(input logic go,
		input logic dir, input logic wk, input logic [7:0] rd,
		input logic [7:0] rc);
		stat_word = {8'h00, rc, rd, 5'h00, wk, dir, go};
	endfunction : stat_word

	assign cmd    = ctrl_q[`CTRL_CMD_LSB +: 8];
	assign ext    = cmd[5:0] == `CMD_EXT_ADDR && cmd[7:6] != `CMD_TX;
	assign free   = !bus.dir && !dir_d1_q;
	assign dvalid = bus.dir && dir_d1_q && dir_d2_q;

	// AHB-Lite slave, zero wait states
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a_act_q    <= 1'b0;
			a_wr_q     <= 1'b0;
			a_ofs_q    <= 8'h00;
			ctrl_q     <= `CTRL_RST;
			start_q    <= 1'b0;
			wake_req_q <= 1'b0;
			hrdata     <= 32'h00000000;
			hreadyout  <= 1'b1;
			hresp      <= 1'b0;
		end else begin
			start_q    <= 1'b0;
			wake_req_q <= 1'b0;
			a_act_q    <= hsel && hready && htrans[1];
			a_wr_q     <= hwrite;
			a_ofs_q    <= haddr[7:0];
			if (hsel && hready && htrans[1] && !hwrite) begin
				if (haddr[7:0] == `LNK_CTRL_OFS)
					hrdata <= ctrl_q;
				else if (haddr[7:0] == `LNK_STAT_OFS)
					hrdata <= stat_word(go_q, bus.dir, wake_q, rdat_q, rxcmd_q);
				else
					hrdata <= 32'h00000000;
			end
			if (a_act_q && a_wr_q && a_ofs_q == `LNK_CTRL_OFS && !go_q) begin
				ctrl_q     <= hwdata & 32'h00FFFFFF;
				start_q    <= hwdata[`CTRL_START_POS];
				wake_req_q <= hwdata[`CTRL_WAKE_POS];
			end
		end
	end

	// Link side sequencing
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q     <= ulpi_pkg::L_IDLE;
			go_q     <= 1'b0;
			wake_q   <= 1'b0;
			done_q   <= 1'b0;
			xsent_q  <= 1'b0;
			stp_q    <= 1'b0;
			oe_n_q   <= 1'b1;
			dout_q   <= `BUS_IDLE;
			rdat_q   <= 8'h00;
			rxcmd_q  <= 8'h00;
			dir_d1_q <= 1'b1;
			dir_d2_q <= 1'b1;
		end else begin
			dir_d1_q <= bus.dir;
			dir_d2_q <= dir_d1_q;
			done_q   <= 1'b0;
			go_q     <= start_q || (go_q && !done_q);
			stp_q    <= 1'b0;
			if (dvalid && !bus.nxt && st_q != ulpi_pkg::L_RWAIT)
				rxcmd_q <= bus.data;
			case (st_q)
				ulpi_pkg::L_IDLE: begin
					dout_q <= `BUS_IDLE;
					oe_n_q <= !free;
					wake_q <= wake_req_q || wake_q;
					if (wake_q && bus.dir) begin
						stp_q  <= 1'b1;
						wake_q <= wake_req_q;
					end else if (go_q && !done_q && free) begin
						dout_q  <= cmd;
						oe_n_q  <= 1'b0;
						xsent_q <= 1'b0;
						st_q    <= ulpi_pkg::L_CMD;
					end
				end
				ulpi_pkg::L_CMD: begin
					if (bus.dir) begin
						oe_n_q <= 1'b1;
						dout_q <= `BUS_IDLE;
						st_q   <= ulpi_pkg::L_IDLE;
					end else if (bus.nxt && ext && !xsent_q) begin
						dout_q  <= ctrl_q[`CTRL_XADDR_LSB +: 8];
						xsent_q <= 1'b1;
					end else if (bus.nxt && cmd[7:6] == `CMD_REG_RD) begin
						dout_q <= `BUS_IDLE;
						st_q   <= ulpi_pkg::L_RWAIT;
					end else if (bus.nxt) begin
						dout_q <= ctrl_q[`CTRL_WDAT_LSB +: 8];
						st_q   <= ulpi_pkg::L_DATA;
					end
				end
				ulpi_pkg::L_DATA: begin
					if (bus.nxt) begin
						dout_q <= `BUS_IDLE;
						stp_q  <= 1'b1;
						st_q   <= ulpi_pkg::L_STP;
					end
				end
				ulpi_pkg::L_STP: begin
					done_q <= 1'b1;
					st_q   <= ulpi_pkg::L_IDLE;
				end
				ulpi_pkg::L_RWAIT: begin
					if (bus.dir)
						oe_n_q <= 1'b1;
					if (dvalid) begin
						rdat_q <= bus.data;
						done_q <= 1'b1;
						st_q   <= ulpi_pkg::L_IDLE;
					end
				end
				default: st_q <= ulpi_pkg::L_IDLE;
			endcase
		end
	end

	assign bus.stp         = stp_q;
	assign bus.link_oe_n   = oe_n_q;
	assign bus.link_data_o = dout_q;
endmodule : ulpi_link_end

// file: rtl/ulpi_phy_end.sv
/*
 * Device end of an 8-bit SDR ULPI interface with its register array,
 * VBUS supply enable, charger pull-up gating and regulator selection.
 * Assumes link inputs and analog status are synchronous to hclk.
 */
// The register offsets and the AHB-Lite slave port are this design's own decisions.
// How it works
// - Supply enable is OR of two bits
// - Both drive bits clear at reset
// - UART mode selects programmed regulator level
// - No line state on bus in UART
// - Pull-ups off while chip reset low
// - DIR high: device drives; low: link drives
// - Take bus when data pending, else listen
// - Hold DIR high until PLL locked
// - One idle turn-around cycle after DIR rises, two after it falls
// - Link STP one cycle ends stream
// - NXT accepts byte; link advances next cycle
// - Only non-zero bus value starts transfer
// - Everything changes on rising clock edge only
// - Low power: clock stopped, line state on bus
// - Low power: interrupt on line/VBUS/ID change
// - STP wakes device from low power
// - Receive path adds a single register stage
// - One decoder routes packets and register accesses
// - Link returns bus to idle after write
// - Command bits 7:6 select command type
`timescale 1ns/10ps
`include "ulpi_defines.svh"
module ulpi_phy_end #(
	parameter logic [1:0] NORMAL_REG_LEVEL = 2'h0
) (
	// Clock and reset
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// Link side
	ulpi_if.phy             bus,
	// Analog status and receiver
	input  wire logic       chip_reset_n,
	input  wire logic       pll_locked,
	input  wire logic [1:0] line_state,
	input  wire logic       vbus_valid,
	input  wire logic       id_gnd,
	input  wire logic       rx_active,
	input  wire logic       rx_valid,
	input  wire logic [7:0] rx_data,
	input  wire logic       tx_ready,
	// Transmitter and control outputs
	output logic [7:0]      tx_data,
	output logic            tx_valid,
	output logic            tx_last,
	output logic            ext_vbus_supply_en,
	output logic            chg_pullup_dp_en,
	output logic            chg_pullup_dm_en,
	output logic [1:0]      regulator_level,
	output logic            uart_active,
	output logic            lpm_active
);
	ulpi_pkg::phy_state_t st_q;
	logic       dir_q, nxt_q, nxt_d1_q, oe_n_q, clk_q;
	logic [7:0] dout_q, cmd_q, addr_q, wdat_q;
	logic       ext_q, rd_pend_q, wr_q, pend_clr_q, mode_clr_q, wake_q;
	logic [7:0] otg_q, iopm_q, mode_q;
	logic [3:0] snap_q;
	logic       pend_q, lp_int_q;
	logic [1:0] div_q;
	logic       acc, ev, has;

	function automatic logic [7:0] reg_read(input logic [7:0] a,
		input logic [7:0] otg, input logic [7:0] iopm,
		input logic [7:0] mode);
		case (a)
			`OTG_CTRL_ADDR: reg_read = otg;
			`IOPM_ADDR:     reg_read = iopm;
			`MODE_ADDR:     reg_read = mode;
			default:        reg_read = 8'h00;
		endcase
	endfunction : reg_read

	function automatic logic [7:0] rx_cmd(input logic [1:0] ls,
		input logic vb, input logic id, input logic rxa, input logic uart);
		rx_cmd = {1'b0, id, 1'b0, rxa, vb, vb,
			uart ? 2'h0 : ls};
	endfunction : rx_cmd

	assign acc = nxt_d1_q;
	assign ev  = {line_state, vbus_valid, id_gnd} != snap_q;
	assign has = rd_pend_q | rx_active | pend_q;

	// Bus ownership and command decoding
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q       <= ulpi_pkg::P_START;
			dir_q      <= 1'b1;
			nxt_q      <= 1'b0;
			nxt_d1_q   <= 1'b0;
			oe_n_q     <= 1'b1;
			dout_q     <= 8'h00;
			cmd_q      <= 8'h00;
			addr_q     <= 8'h00;
			wdat_q     <= 8'h00;
			ext_q      <= 1'b0;
			rd_pend_q  <= 1'b0;
			wr_q       <= 1'b0;
			pend_clr_q <= 1'b0;
			mode_clr_q <= 1'b0;
			wake_q     <= 1'b0;
			tx_data    <= 8'h00;
			tx_valid   <= 1'b0;
			tx_last    <= 1'b0;
		end else begin
			nxt_d1_q   <= nxt_q;
			wr_q       <= 1'b0;
			pend_clr_q <= 1'b0;
			mode_clr_q <= 1'b0;
			wake_q     <= 1'b0;
			tx_valid   <= 1'b0;
			tx_last    <= 1'b0;
			case (st_q)
				ulpi_pkg::P_START: begin
					if (pll_locked) begin
						dir_q  <= 1'b0;
						wake_q <= 1'b1;
						st_q   <= ulpi_pkg::P_TADN;
					end
				end
				ulpi_pkg::P_IDLE: begin
					if (!pll_locked) begin
						dir_q <= 1'b1;
						st_q  <= ulpi_pkg::P_START;
					end else if (has || mode_q[1:0] != 2'h0) begin
						dir_q <= 1'b1;
						st_q  <= ulpi_pkg::P_TA1;
					end else if (bus.data != `BUS_IDLE) begin
						cmd_q  <= bus.data;
						addr_q <= {2'h0, bus.data[5:0]};
						ext_q  <= bus.data[5:0] == `CMD_EXT_ADDR;
						nxt_q  <= 1'b1;
						case (bus.data[7:6])
							`CMD_REG_RD: st_q <= ulpi_pkg::P_RCMD;
							`CMD_TX: begin
								ext_q    <= 1'b0;
								tx_data  <= bus.data;
								tx_valid <= 1'b1;
								nxt_q    <= tx_ready;
								st_q     <= ulpi_pkg::P_TX;
							end
							default: st_q <= ulpi_pkg::P_CMD;
						endcase
					end
				end
				ulpi_pkg::P_CMD: begin
					if (acc && ext_q) begin
						addr_q <= bus.data;
						ext_q  <= 1'b0;
					end else if (acc) begin
						wdat_q <= bus.data;
						nxt_q  <= 1'b0;
						st_q   <= ulpi_pkg::P_WSTP;
					end
				end
				ulpi_pkg::P_WSTP: begin
					if (bus.stp) begin
						wr_q <= 1'b1;
						st_q <= ulpi_pkg::P_IDLE;
					end
				end
				ulpi_pkg::P_RCMD: begin
					if (!ext_q || acc) begin
						if (ext_q)
							addr_q <= bus.data;
						ext_q     <= 1'b0;
						nxt_q     <= 1'b0;
						dir_q     <= 1'b1;
						rd_pend_q <= 1'b1;
						st_q      <= ulpi_pkg::P_TA1;
					end
				end
				ulpi_pkg::P_TX: begin
					if (bus.stp) begin
						tx_last <= 1'b1;
						nxt_q   <= 1'b0;
						st_q    <= ulpi_pkg::P_IDLE;
					end else begin
						nxt_q <= tx_ready;
						if (acc) begin
							tx_data  <= bus.data;
							tx_valid <= 1'b1;
						end
					end
				end
				// Link still driving the bus this cycle, contents ignored
				ulpi_pkg::P_TA1: st_q <= ulpi_pkg::P_TA2;
				ulpi_pkg::P_TA2, ulpi_pkg::P_SEND: begin
					if (st_q == ulpi_pkg::P_TA2 && !rd_pend_q &&
						mode_q[`MODE_UART_POS]) begin
						oe_n_q <= 1'b0;
						dout_q <= 8'h00;
						st_q   <= ulpi_pkg::P_UART;
					end else if (st_q == ulpi_pkg::P_TA2 && !rd_pend_q &&
						mode_q[`MODE_LPM_POS]) begin
						oe_n_q <= 1'b0;
						dout_q <= {6'h00, line_state};
						st_q   <= ulpi_pkg::P_LPM;
					end else if (has) begin
						oe_n_q <= 1'b0;
						st_q   <= ulpi_pkg::P_SEND;
						if (rd_pend_q) begin
							dout_q    <= reg_read(addr_q, otg_q, iopm_q, mode_q);
							nxt_q     <= 1'b0;
							rd_pend_q <= 1'b0;
						end else if (rx_active && rx_valid) begin
							dout_q <= rx_data;
							nxt_q  <= 1'b1;
						end else begin
							dout_q     <= rx_cmd(line_state, vbus_valid, id_gnd,
								rx_active, 1'b0);
							nxt_q      <= 1'b0;
							pend_clr_q <= 1'b1;
						end
					end else begin
						dir_q  <= 1'b0;
						oe_n_q <= 1'b1;
						nxt_q  <= 1'b0;
						st_q   <= ulpi_pkg::P_TADN;
					end
				end
				ulpi_pkg::P_LPM, ulpi_pkg::P_UART: begin
					if (bus.stp) begin
						dir_q      <= 1'b0;
						oe_n_q     <= 1'b1;
						mode_clr_q <= 1'b1;
						wake_q     <= 1'b1;
						st_q       <= ulpi_pkg::P_TADN;
					end else if (st_q == ulpi_pkg::P_LPM) begin
						dout_q <= {4'h0, lp_int_q, 1'b0, line_state};
					end else begin
						dout_q <= 8'h00;
					end
				end
				ulpi_pkg::P_TADN: st_q <= ulpi_pkg::P_IDLE;
				default: st_q <= ulpi_pkg::P_START;
			endcase
		end
	end

	// Register array written by the decoder
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			otg_q  <= `OTG_CTRL_RST;
			iopm_q <= `IOPM_RST;
			mode_q <= `MODE_RST;
		end else begin
			if (wr_q && addr_q == `OTG_CTRL_ADDR)
				otg_q <= wdat_q;
			if (wr_q && addr_q == `IOPM_ADDR)
				iopm_q <= wdat_q;
			if (wr_q && addr_q == `MODE_ADDR)
				mode_q <= wdat_q;
			else if (mode_clr_q)
				mode_q <= mode_q & 8'hFC;
		end
	end

	// Status change tracking; a new change beats a clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			snap_q   <= 4'h0;
			pend_q   <= 1'b0;
			lp_int_q <= 1'b0;
		end else begin
			snap_q <= {line_state, vbus_valid, id_gnd};
			pend_q <= ev || wake_q || (pend_q && !pend_clr_q);
			if (st_q == ulpi_pkg::P_LPM)
				lp_int_q <= lp_int_q || ev;
			else
				lp_int_q <= 1'b0;
		end
	end

	// Control outputs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ext_vbus_supply_en <= 1'b0;
			chg_pullup_dp_en   <= 1'b0;
			chg_pullup_dm_en   <= 1'b0;
			regulator_level    <= 2'h0;
			uart_active        <= 1'b0;
			lpm_active         <= 1'b0;
		end else begin
			ext_vbus_supply_en <= otg_q[`DRV_VBUS_POS] ||
				otg_q[`DRV_VBUS_EXT_POS];
			chg_pullup_dp_en <= chip_reset_n && iopm_q[`CHG_DP_POS];
			chg_pullup_dm_en <= chip_reset_n && iopm_q[`CHG_DM_POS];
			regulator_level  <= (st_q == ulpi_pkg::P_UART) ?
				iopm_q[`UART_LVL_LSB +: 2] : NORMAL_REG_LEVEL;
			uart_active <= st_q == ulpi_pkg::P_UART;
			lpm_active  <= st_q == ulpi_pkg::P_LPM;
		end
	end

	// Interface clock output, held low in low power
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_q <= 2'h0;
			clk_q <= 1'b0;
		end else if (st_q == ulpi_pkg::P_LPM) begin
			div_q <= 2'h0;
			clk_q <= 1'b0;
		end else if (div_q >= 2'(`PHY_CLK_HALF_CYC - 1)) begin
			div_q <= 2'h0;
			clk_q <= !clk_q;
		end else begin
			div_q <= div_q + 2'h1;
		end
	end

	assign bus.dir           = dir_q;
	assign bus.nxt           = nxt_q;
	assign bus.phy_oe_n      = oe_n_q;
	assign bus.phy_data_o    = dout_q;
	assign bus.phy_clock_out = clk_q;
endmodule : ulpi_phy_end

// file: rtl/ulpi_pkg.sv
/*
 * Types of both ULPI ends: state enumerations.
 * Assumes nothing beyond the shared defines header.
 */
package ulpi_pkg;
	typedef enum logic [3:0] {
		P_START, P_IDLE, P_CMD, P_WSTP, P_RCMD, P_TA1, P_TA2,
		P_SEND, P_TADN, P_TX, P_LPM, P_UART
	} phy_state_t;

	typedef enum logic [2:0] {
		L_IDLE, L_CMD, L_DATA, L_STP, L_RWAIT
	} link_state_t;
endpackage : ulpi_pkg

// file: tb/tb_top.sv
/*
 * Self-checking bench: both ULPI ends joined, link driven over AHB-Lite.
 * Assumes the designer's defines, package and interface compiled first.
 */
`timescale 1ns/10ps
`include "ulpi_defines.svh"
module tb_top;
	typedef struct packed {
		logic [7:0] cmd;
		logic [7:0] xa;
		logic [7:0] wd;
		logic [2:0] pins;
	} row_t;

	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b1;
	logic        hwrite = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
	logic        hreadyout, hresp;
	logic        chip_reset_n = 1'b1, pll_locked = 1'b0, vbus_valid = 1'b1;
	logic        id_gnd = 1'b0, rx_active = 1'b0, rx_valid = 1'b0;
	logic        tx_ready = 1'b1;
	logic [1:0]  line_state = 2'h1;
	logic [7:0]  rx_data = 8'h00;
	logic [7:0]  tx_data;
	logic [1:0]  regulator_level;
	logic        tx_valid, tx_last, ext_vbus_supply_en, chg_pullup_dp_en;
	logic        chg_pullup_dm_en, uart_active, lpm_active;
	logic [7:0]  tx_b [2];
	int          bad_count = 0, num_checks = 0, tx_n = 0, last_n = 0;
	// Command, extended address, data, expected {vbus, dp, dm}
	row_t        rows [8] = '{
		{8'h8A, 8'h00, 8'h20, 3'b100}, {8'h8A, 8'h00, 8'h40, 3'b100},
		{8'hAF, 8'h0A, 8'h60, 3'b100}, {8'h8A, 8'h00, 8'h00, 3'b000},
		{8'hB9, 8'h00, 8'h01, 3'b010}, {8'hAF, 8'h39, 8'h02, 3'b001},
		{8'hB9, 8'h00, 8'h03, 3'b011}, {8'hAF, 8'h0A, 8'h20, 3'b111}};

	always #4 hclk = ~hclk;

	ulpi_if ulpi_if_inst ();
	ulpi_phy_end ulpi_phy_end_inst (.hclk(hclk), .hresetn(hresetn),
		.bus(ulpi_if_inst), .chip_reset_n(chip_reset_n),
		.pll_locked(pll_locked), .line_state(line_state),
		.vbus_valid(vbus_valid), .id_gnd(id_gnd), .rx_active(rx_active),
		.rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
		.ext_vbus_supply_en(ext_vbus_supply_en),
		.chg_pullup_dp_en(chg_pullup_dp_en),
		.chg_pullup_dm_en(chg_pullup_dm_en),
		.regulator_level(regulator_level), .uart_active(uart_active),
		.lpm_active(lpm_active));
	ulpi_link_end ulpi_link_end_inst (.hclk(hclk), .hresetn(hresetn),
		.bus(ulpi_if_inst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
	ulpi_wire_assertions ulpi_wire_assertions_inst (.hclk(hclk),
		.hresetn(hresetn), .dir(ulpi_if_inst.dir), .nxt(ulpi_if_inst.nxt),
		.stp(ulpi_if_inst.stp), .phy_clock_out(ulpi_if_inst.phy_clock_out),
		.phy_oe_n(ulpi_if_inst.phy_oe_n), .link_oe_n(ulpi_if_inst.link_oe_n),
		.data(ulpi_if_inst.data));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic ahb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] r);
		htrans <= 2'h2;
		haddr  <= {24'h000000, a};
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : ahb

	// Poll until neither busy nor wake pending
	task automatic wait_idle;
		int n;
		n = 0;
		do begin
			ahb(1'b0, `LNK_STAT_OFS, 32'h0, rd);
			n++;
		end while ((rd[0] | rd[2]) !== 1'b0 && n < 200);
		if (n >= 200) chk(rd, 32'h0);
	endtask : wait_idle

	task automatic op(input logic [7:0] cmd, xa, wd, input logic wake);
		ahb(1'b1, `LNK_CTRL_OFS, {6'h00, wake, !wake, xa, wd, cmd}, rd);
		repeat (4) @(posedge hclk);
		wait_idle();
	endtask : op

	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : results

	always @(negedge hclk) begin
		if (tx_valid === 1'b1) begin
			if (tx_n < 2) tx_b[tx_n] = tx_data;
			tx_n++;
		end
		if (tx_last === 1'b1) last_n++;
	end

	initial begin
		#160000;
		bad_count++;
		results();
	end

	initial begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (6) @(negedge hclk);
		chk({ext_vbus_supply_en, ulpi_if_inst.dir}, 2'b01);
		@(posedge hclk);
		pll_locked <= 1'b1;
		repeat (30) @(negedge hclk);
		chk(ulpi_if_inst.dir, 1'b0);
		@(posedge hclk);
		ahb(1'b0, `LNK_STAT_OFS, 32'h0, rd);
		chk(rd[23:16], 8'h0D);
		foreach (rows[i]) begin
			op(rows[i].cmd, rows[i].xa, rows[i].wd, 1'b0);
			chk({ext_vbus_supply_en, chg_pullup_dp_en, chg_pullup_dm_en},
				rows[i].pins);
			op({2'b11, rows[i].cmd[5:0]}, rows[i].xa, 8'h00, 1'b0);
			chk(rd[15:8], rows[i].wd);
		end
		chip_reset_n <= 1'b0;
		repeat (3) @(negedge hclk);
		chk({chg_pullup_dp_en, chg_pullup_dm_en}, 2'b00);
		@(posedge hclk);
		chip_reset_n <= 1'b1;
		repeat (3) @(negedge hclk);
		chk({chg_pullup_dp_en, chg_pullup_dm_en}, 2'b11);
		@(posedge hclk);
		ahb(1'b1, 8'h08, 32'hFFFFFFFF, rd);
		ahb(1'b0, 8'h08, 32'h0, rd);
		chk(rd, 32'h0);
		chk({hreadyout, hresp}, 2'b10);
		tx_ready <= 1'b0;
		ahb(1'b1, `LNK_CTRL_OFS, 32'h0100A541, rd);
		repeat (12) @(negedge hclk);
		chk(tx_n > 1, 1'b0);
		@(posedge hclk);
		tx_ready <= 1'b1;
		wait_idle();
		chk({tx_b[0], tx_b[1]}, 16'h41A5);
		chk(last_n, 1);
		op(8'hB9, 8'h00, 8'h08, 1'b0);
		op(8'hBA, 8'h00, 8'h02, 1'b0);
		line_state <= 2'h2;
		repeat (10) @(negedge hclk);
		chk({uart_active, regulator_level, ulpi_if_inst.dir}, 4'hD);
		chk(ulpi_if_inst.data, 8'h00);
		@(posedge hclk);
		op(8'h00, 8'h00, 8'h00, 1'b1);
		chk({uart_active, regulator_level}, 3'h0);
		repeat (20) @(posedge hclk);
		ahb(1'b0, `LNK_STAT_OFS, 32'h0, rd);
		chk(rd[23:16], 8'h0E);
		op(8'hBA, 8'h00, 8'h01, 1'b0);
		repeat (10) @(negedge hclk);
		chk({lpm_active, ulpi_if_inst.data[1:0]}, 3'h6);
		chk(ulpi_if_inst.phy_clock_out, 1'b0);
		@(posedge hclk);
		id_gnd <= 1'b1;
		repeat (5) @(negedge hclk);
		chk(ulpi_if_inst.data[3], 1'b1);
		chk(ulpi_if_inst.phy_clock_out, 1'b0);
		@(posedge hclk);
		op(8'h00, 8'h00, 8'h00, 1'b1);
		chk(lpm_active, 1'b0);
		rx_active <= 1'b1;
		rx_valid  <= 1'b1;
		rx_data   <= 8'h5A;
		repeat (6) @(negedge hclk);
		chk({ulpi_if_inst.dir, ulpi_if_inst.nxt, ulpi_if_inst.data},
			10'h35A);
		@(posedge hclk);
		rx_valid <= 1'b0;
		repeat (3) @(posedge hclk);
		rx_active <= 1'b0;
		repeat (10) @(posedge hclk);
		ahb(1'b0, `LNK_STAT_OFS, 32'h0, rd);
		chk(rd[23:16], 8'h5E);
		hresetn <= 1'b0;
		repeat (2) @(negedge hclk);
		chk({ext_vbus_supply_en, ulpi_if_inst.dir}, 2'b01);
		@(posedge hclk);
		hresetn <= 1'b1;
		repeat (30) @(posedge hclk);
		op(8'hCA, 8'h00, 8'h00, 1'b0);
		chk(rd[15:8], 8'h00);
		results();
	end
endmodule : tb_top

// file: tb/ulpi_wire_assertions.sv
/*
 * Wire-level checks between the device end and the link end of ULPI.
 * Assumes one hclk domain and an active-low asynchronous hresetn.
 */
`timescale 1ns/10ps
module ulpi_wire_assertions (
	// Clock and reset
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// Interface wires
	input  wire logic       dir,
	input  wire logic       nxt,
	input  wire logic       stp,
	input  wire logic       phy_clock_out,
	input  wire logic       phy_oe_n,
	input  wire logic       link_oe_n,
	input  wire logic [7:0] data
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	a_one_driver: assert property (phy_oe_n || link_oe_n)
		else $error("both ends drive the data bus");
	a_phy_needs_dir: assert property (!phy_oe_n |-> dir)
		else $error("device drives the bus with dir low");
	a_link_held_off: assert property (
		dir && $past(dir) |-> link_oe_n)
		else $error("link drives the bus while dir high");
	a_rise_turn: assert property (
		$rose(dir) |-> phy_oe_n ##1 (phy_oe_n && link_oe_n))
		else $error("bus driven in turn-around after dir rose");
	a_fall_turn: assert property (
		$fell(dir) |-> phy_oe_n && link_oe_n)
		else $error("bus driven in turn-around after dir fell");
	a_stp_pulse: assert property (stp |=> !stp)
		else $error("stop held longer than one cycle");
	a_nxt_link_drives: assert property (
		nxt && !dir |-> !link_oe_n)
		else $error("next asserted while link not driving");
	a_nxt_needs_cmd: assert property (
		$rose(nxt) && !dir |-> $past(data) != 8'h00)
		else $error("next raised for an idle bus value");
	a_clock_runs: assert property (
		!dir && !$past(dir) |->
		phy_clock_out != $past(phy_clock_out))
		else $error("interface clock not running");
endmodule : ulpi_wire_assertions
